/* File: testbench/dbgcp_host.sv */
// Debug host model: sends command bytes, collects response bytes
`timescale 1ns/1ps
`default_nettype none
module dbgcp_host (
    input wire logic clk,
    input wire logic slow,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte
);
    logic [7:0] got_q[$];
    logic [31:0] r;
    integer seed = 32'hd8f1;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end
    // Slow mode stalls the response path at random
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got_q.push_back(tx_byte);
        end
        r = $random(seed);
        tx_ready <= slow ? r[0] : 1'b1;
    end
    // one byte per call, caller drains replies first
    task automatic send(input logic [7:0] v);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_byte <= v;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~v;
    endtask : send
    // Bounded wait so a missing reply shows as unknown
    task automatic take(output logic [7:0] v);
        int n = 0;
        while (got_q.size() == 0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        v = (got_q.size() != 0) ? got_q.pop_front() : 8'hxx;
    endtask : take
endmodule : dbgcp_host
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the debug command port
`timescale 1ns/1ps
`default_nettype none
`include "dbgcp_defs.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic prot = 1'b0;
    logic bp = 1'b0;
    logic ow = 1'b0;
    logic done = 1'b0;
    logic [7:0] stat = 8'h00;
    logic [15:0] ow_val = 16'h0000;
    logic rx_valid, tx_ready, tx_valid, halt, nop, rreq, pc_load;
    logic [7:0] rx_byte, tx_byte, b;
    logic [7:0] ctl = 8'h00;
    logic [15:0] pc_value, pc_seen, w;
    logic [31:0] r;
    integer seed = 32'hd8f1;
    integer mismatches = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    integer loads = 0;
    dbgcp_top uut (.CORE_CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
        .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .DEBUG_STATUS(stat),
        .READ_PROTECT(prot), .BREAKPOINT_DECODED(bp), .RTC_OVERWRITE(ow),
        .RTC_OVERWRITE_VAL(ow_val), .SYS_RESET_DONE(done), .CPU_HALT(halt),
        .BREAKPOINT_AS_NOP(nop), .SYS_RESET_REQ(rreq), .PC_LOAD(pc_load),
        .PC_VALUE(pc_value));
    dbgcp_host host (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte));
    always #50 clk = ~clk;
    // Timeout well above the roughly 300 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pc_load === 1'b1) begin
            loads <= loads + 1;
            pc_seen <= pc_value;
        end
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_word(input string what, input logic [15:0] lo, input logic [15:0] hi,
        input logic [15:0] got);
        cmp_count++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask : chk_word
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic wctl(input logic [7:0] v);
        host.send(`DBGCP_CMD_WCTL);
        host.send(v);
        ctl = (v & 8'he1) | ((prot && ctl[7]) ? 8'h80 : 8'h00);
        settle(2);
        chk_bit("halt", ctl[7], halt);
        chk_bit("nop", ~ctl[6], nop);
        chk_bit("reset_req", ctl[0], rreq);
        if (ctl[0]) begin
            @(posedge clk) done <= 1'b1;
            @(posedge clk) done <= 1'b0;
            settle(2);
            ctl[0] = 1'b0;
            chk_bit("reset_req", 1'b0, rreq);
        end
        host.send(`DBGCP_CMD_RCTL);
        host.take(b);
        chk_byte("control", ctl, b);
    endtask : wctl
    task automatic pulse_bp();
        @(posedge clk) bp <= 1'b1;
        @(posedge clk) bp <= 1'b0;
        settle(2);
        ctl[7] = ctl[7] | ctl[6];
        chk_bit("halt", ctl[7], halt);
    endtask : pulse_bp
    task automatic rtc(output logic [15:0] v);
        host.send(`DBGCP_CMD_RTC);
        host.take(v[15:8]);
        host.take(v[7:0]);
    endtask : rtc
    task automatic wpc(input logic [15:0] v, input logic keep);
        int n0 = loads;
        host.send(`DBGCP_CMD_WPC);
        host.send(v[15:8]);
        host.send(v[7:0]);
        settle(3);
        chk_bit("pc_load", keep, loads != n0);
        if (keep) chk_word("pc", v, v, pc_seen);
    endtask : wpc
    task automatic overwrite(input logic [15:0] v);
        @(posedge clk) ow <= 1'b1;
        ow_val <= v;
        @(posedge clk) ow <= 1'b0;
    endtask : overwrite
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk_bit("nop", 1'b1, nop);
        slow <= 1'b1;
        host.send(`DBGCP_CMD_REV);
        host.take(b);
        chk_byte("rev_major", `DBGCP_REV_MAJOR, b);
        host.take(b);
        chk_byte("rev_minor", `DBGCP_REV_MINOR, b);
        repeat (4) begin
            r = $random(seed);
            @(posedge clk) stat <= r[7:0];
            host.send(`DBGCP_CMD_STAT);
            host.take(b);
            chk_byte("status", stat, b);
        end
        repeat (8) begin
            r = $random(seed);
            wctl(r[7:0]);
        end
        @(posedge clk) slow <= 1'b0;
        wctl(8'h60);
        pulse_bp();
        host.take(b);
        chk_byte("ack", `DBGCP_ACK_CHAR, b);
        rtc(w);
        chk_word("runtime", 16'h0000, 16'h0040, w);
        wpc(r[15:0], ctl[7] & ~prot);
        wctl(8'h40);
        pulse_bp();
        settle(20);
        chk_bit("ack_absent", 1'b0, host.got_q.size() != 0);
        wctl(8'h00);
        wpc(r[31:16], 1'b0);
        pulse_bp();
        @(posedge clk) prot <= 1'b1;
        wctl(8'h80);
        wpc(r[15:0], 1'b0);
        wctl(8'h00);
        @(posedge clk) rst <= 1'b1;
        prot <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        ctl = 8'h00;
        chk_bit("halt", 1'b0, halt);
        overwrite(16'hfff8);
        settle(30);
        rtc(w);
        chk_word("runtime", 16'hffff, 16'hffff, w);
        overwrite(16'h1234);
        rtc(w);
        chk_word("runtime", 16'h1234, 16'h1260, w);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire

/* File: verilog/dbgcp_defs.svh */
// Constants of the debug command port
`ifndef DBGCP_DEFS_SVH
`define DBGCP_DEFS_SVH
`define DBGCP_CMD_REV 8'h00
`define DBGCP_CMD_STAT 8'h02
`define DBGCP_CMD_RTC 8'h03
`define DBGCP_CMD_WCTL 8'h04
`define DBGCP_CMD_RCTL 8'h05
`define DBGCP_CMD_WPC 8'h06
`define DBGCP_CTL_HALT 7
`define DBGCP_CTL_BPEN 6
`define DBGCP_CTL_ACKEN 5
`define DBGCP_CTL_RST 0
`define DBGCP_CTL_WMASK 8'he1
`define DBGCP_CTL_RESET 8'h00
`define DBGCP_ACK_CHAR 8'hff
`define DBGCP_RTC_MAX 16'hffff
`define DBGCP_RTC_ZERO 16'h0000
`define DBGCP_REV_MAJOR 8'h01
`define DBGCP_REV_MINOR 8'h00
`endif

/* File: verilog/dbgcp_pkg.sv */
// Types of the debug command port
package dbgcp_pkg;
    typedef enum logic [2:0] {
        DBGCP_IDLE = 3'b000,
        DBGCP_SEND = 3'b001,
        DBGCP_WCTL = 3'b010,
        DBGCP_WPCH = 3'b011,
        DBGCP_WPCL = 3'b100
    } dbgcp_state_e;
endpackage : dbgcp_pkg

/* File: verilog/dbgcp_runtime.sv */
// Saturating runtime counter between breakpoints
`timescale 1ns/1ps
`default_nettype none
`include "dbgcp_defs.svh"
module dbgcp_runtime
    import dbgcp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic overwrite,
    input wire logic [15:0] overwrite_val,
    output logic [15:0] count
);
    logic [15:0] count_reg;
    logic [15:0] count_next;
    always_comb begin
        if (restart) begin
            count_next = `DBGCP_RTC_ZERO;
        end else if (overwrite) begin
            count_next = overwrite_val;
        end else if (count_reg != `DBGCP_RTC_MAX) begin
            count_next = count_reg + 16'h0001;
        end else begin
            count_next = count_reg;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= `DBGCP_RTC_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end
    assign count = count_reg;
    property p_rtc_hold;
        @(posedge clk) disable iff (rst)
        (count_reg == `DBGCP_RTC_MAX && !restart && !overwrite) |=> (count_reg == `DBGCP_RTC_MAX);
    endproperty
    a_rtc_hold: assert property (p_rtc_hold) else $error("runtime counter wrapped");
    property p_rtc_inc;
        @(posedge clk) disable iff (rst)
        (count_reg != `DBGCP_RTC_MAX && !restart && !overwrite) |=> (count_reg == $past(count_reg) + 16'h0001);
    endproperty
    a_rtc_inc: assert property (p_rtc_inc) else $error("runtime counter did not step");
    property p_rtc_restart;
        @(posedge clk) disable iff (rst)
        restart |=> (count_reg == `DBGCP_RTC_ZERO);
    endproperty
    a_rtc_restart: assert property (p_rtc_restart) else $error("runtime counter not restarted");
endmodule : dbgcp_runtime
`default_nettype wire

/* File: verilog/dbgcp_top.sv */
// Command handler of the on-chip debug unit
`timescale 1ns/1ps
`default_nettype none
`include "dbgcp_defs.svh"
module dbgcp_top
    import dbgcp_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_BYTE,
    input wire logic TX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_BYTE,
    input wire logic [7:0] DEBUG_STATUS,
    input wire logic READ_PROTECT,
    input wire logic BREAKPOINT_DECODED,
    input wire logic RTC_OVERWRITE,
    input wire logic [15:0] RTC_OVERWRITE_VAL,
    input wire logic SYS_RESET_DONE,
    output logic CPU_HALT,
    output logic BREAKPOINT_AS_NOP,
    output logic SYS_RESET_REQ,
    output logic PC_LOAD,
    output logic [15:0] PC_VALUE
);
    ////////////////////////////////////////////////////////////////////////
    dbgcp_state_e state_reg, state_next;
    logic [7:0] ctl_reg, ctl_next;
    logic [7:0] tx_byte_reg, tx_byte_next;
    logic tx_valid_reg, tx_valid_next;
    logic [7:0] second_reg, second_next;
    logic more_reg, more_next;
    logic [7:0] pch_reg, pch_next;
    logic [15:0] pc_reg, pc_next;
    logic pc_load_reg, pc_load_next;
    logic ack_pend_reg, ack_pend_next;
    logic nop_reg, nop_next;
    logic bp_hit;
    logic [15:0] rtc;
    logic tx_free;
    logic [7:0] ctl_rd;

    // Breakpoint only counts when enabled; otherwise the opcode passes as nop
    assign bp_hit = BREAKPOINT_DECODED & ctl_reg[`DBGCP_CTL_BPEN];
    assign tx_free = !tx_valid_reg || TX_READY;
    assign ctl_rd = ctl_reg & `DBGCP_CTL_WMASK;

    dbgcp_runtime u_rtc (
        .clk(CORE_CLK),
        .rst(RST),
        .restart(bp_hit),
        .overwrite(RTC_OVERWRITE),
        .overwrite_val(RTC_OVERWRITE_VAL),
        .count(rtc)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        ctl_next = ctl_reg;
        tx_byte_next = tx_byte_reg;
        tx_valid_next = tx_valid_reg && !TX_READY;
        second_next = second_reg;
        more_next = more_reg;
        pch_next = pch_reg;
        pc_next = pc_reg;
        pc_load_next = 1'b0;
        ack_pend_next = ack_pend_reg;
        if (SYS_RESET_DONE) begin
            ctl_next[`DBGCP_CTL_RST] = 1'b0;
        end
        if (bp_hit && ctl_reg[`DBGCP_CTL_ACKEN]) begin
            ack_pend_next = 1'b1;
        end
        unique case (state_reg)
            DBGCP_IDLE: begin
                if (ack_pend_reg && tx_free) begin
                    tx_byte_next = `DBGCP_ACK_CHAR;
                    tx_valid_next = 1'b1;
                    ack_pend_next = bp_hit && ctl_reg[`DBGCP_CTL_ACKEN];
                end else if (RX_VALID) begin
                    more_next = 1'b0;
                    unique case (RX_BYTE)
                        `DBGCP_CMD_REV: begin
                            tx_byte_next = `DBGCP_REV_MAJOR;
                            second_next = `DBGCP_REV_MINOR;
                            more_next = 1'b1;
                            state_next = DBGCP_SEND;
                        end
                        `DBGCP_CMD_STAT: begin
                            tx_byte_next = DEBUG_STATUS;
                            state_next = DBGCP_SEND;
                        end
                        `DBGCP_CMD_RTC: begin
                            tx_byte_next = rtc[15:8];
                            second_next = rtc[7:0];
                            more_next = 1'b1;
                            state_next = DBGCP_SEND;
                        end
                        `DBGCP_CMD_WCTL: state_next = DBGCP_WCTL;
                        `DBGCP_CMD_RCTL: begin
                            tx_byte_next = ctl_rd;
                            state_next = DBGCP_SEND;
                        end
                        `DBGCP_CMD_WPC: state_next = DBGCP_WPCH;
                        default: state_next = DBGCP_IDLE;
                    endcase
                end
            end
            DBGCP_SEND: begin
                if (!tx_valid_reg) begin
                    tx_valid_next = 1'b1;
                    if (!more_reg) begin
                        state_next = DBGCP_IDLE;
                    end
                end else if (TX_READY) begin
                    if (more_reg) begin
                        tx_byte_next = second_reg;
                        tx_valid_next = 1'b1;
                        more_next = 1'b0;
                    end
                    state_next = DBGCP_IDLE;
                end
            end
            DBGCP_WCTL: begin
                if (RX_VALID) begin
                    ctl_next = RX_BYTE & `DBGCP_CTL_WMASK;
                    if (READ_PROTECT && ctl_reg[`DBGCP_CTL_HALT]) begin
                        ctl_next[`DBGCP_CTL_HALT] = 1'b1;
                    end
                    state_next = DBGCP_IDLE;
                end
            end
            DBGCP_WPCH: begin
                if (RX_VALID) begin
                    pch_next = RX_BYTE;
                    state_next = DBGCP_WPCL;
                end
            end
            DBGCP_WPCL: begin
                if (RX_VALID) begin
                    if (ctl_reg[`DBGCP_CTL_HALT] && !READ_PROTECT) begin
                        pc_next = {pch_reg, RX_BYTE};
                        pc_load_next = 1'b1;
                    end
                    state_next = DBGCP_IDLE;
                end
            end
            default: state_next = DBGCP_IDLE;
        endcase
        if (bp_hit) begin
            ctl_next[`DBGCP_CTL_HALT] = 1'b1;
        end
        nop_next = !ctl_next[`DBGCP_CTL_BPEN];
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= DBGCP_IDLE;
            ctl_reg <= `DBGCP_CTL_RESET;
            tx_byte_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            second_reg <= 8'h00;
            more_reg <= 1'b0;
            pch_reg <= 8'h00;
            pc_reg <= 16'h0000;
            pc_load_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            nop_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            ctl_reg <= ctl_next;
            tx_byte_reg <= tx_byte_next;
            tx_valid_reg <= tx_valid_next;
            second_reg <= second_next;
            more_reg <= more_next;
            pch_reg <= pch_next;
            pc_reg <= pc_next;
            pc_load_reg <= pc_load_next;
            ack_pend_reg <= ack_pend_next;
            nop_reg <= nop_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign TX_VALID = tx_valid_reg;
    assign TX_BYTE = tx_byte_reg;
    assign CPU_HALT = ctl_reg[`DBGCP_CTL_HALT];
    assign BREAKPOINT_AS_NOP = nop_reg;
    assign SYS_RESET_REQ = ctl_reg[`DBGCP_CTL_RST];
    assign PC_LOAD = pc_load_reg;
    assign PC_VALUE = pc_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_bp_halt;
        @(posedge CORE_CLK) disable iff (RST)
        (BREAKPOINT_DECODED && ctl_reg[`DBGCP_CTL_BPEN]) |=> CPU_HALT;
    endproperty
    a_bp_halt: assert property (p_bp_halt) else $error("breakpoint did not halt");
    property p_prot_halt;
        @(posedge CORE_CLK) disable iff (RST)
        (READ_PROTECT && $past(READ_PROTECT) && $past(CPU_HALT)) |-> CPU_HALT;
    endproperty
    a_prot_halt: assert property (p_prot_halt) else $error("protected halt cleared");
    property p_resv_zero;
        @(posedge CORE_CLK) disable iff (RST)
        ctl_reg[4:1] == 4'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits set");
    property p_pc_gate;
        @(posedge CORE_CLK) disable iff (RST)
        PC_LOAD |-> ($past(CPU_HALT) && !$past(READ_PROTECT));
    endproperty
    a_pc_gate: assert property (p_pc_gate) else $error("pc loaded when not allowed");
    property p_wctl;
        @(posedge CORE_CLK) disable iff (RST)
        (state_reg == DBGCP_WCTL && RX_VALID && !READ_PROTECT && !BREAKPOINT_DECODED
            && !SYS_RESET_DONE)
            |=> (ctl_reg == ($past(RX_BYTE) & `DBGCP_CTL_WMASK));
    endproperty
    a_wctl: assert property (p_wctl) else $error("control write lost");
    property p_stat;
        @(posedge CORE_CLK) disable iff (RST)
        (state_reg == DBGCP_IDLE && !ack_pend_reg && RX_VALID && RX_BYTE == `DBGCP_CMD_STAT)
            |=> (tx_byte_reg == $past(DEBUG_STATUS));
    endproperty
    a_stat: assert property (p_stat) else $error("status byte wrong");
    property p_rst_clear;
        @(posedge CORE_CLK) disable iff (RST)
        (SYS_RESET_DONE && !(state_reg == DBGCP_WCTL && RX_VALID)) |=> !SYS_RESET_REQ;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset bit stuck");
    property p_ack;
        @(posedge CORE_CLK) disable iff (RST)
        (bp_hit && ctl_reg[`DBGCP_CTL_ACKEN]) |=> ack_pend_reg;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not queued");
    property p_pair;
        @(posedge CORE_CLK) disable iff (RST)
        (state_reg == DBGCP_SEND && more_reg && tx_valid_reg && TX_READY)
            |=> (TX_VALID && TX_BYTE == $past(second_reg));
    endproperty
    a_pair: assert property (p_pair) else $error("second byte not sent");
    c_rev: cover property (@(posedge CORE_CLK) RX_VALID && RX_BYTE == `DBGCP_CMD_REV);
    c_pc: cover property (@(posedge CORE_CLK) PC_LOAD);
    c_bp: cover property (@(posedge CORE_CLK) bp_hit);
endmodule : dbgcp_top
`default_nettype wire
